/* hw/bec_top.v */
// Purpose: break event detection and combination over two data events
// Assumes: one bus cycle per clock when cyc_valid is high
// Notes:   break_hit is sticky until the next arm
// How it works
// R1: eight data conditions including equal and range
// R2: access qualifier read, write or either
// R3: sixteen-bit mask selects compared data bits
// R4: odd word write uses two ANDed events
// R5: even byte write compares low lane
// R6: odd byte write compares high lane
// R7: AND breaks once all events occurred
// R8: same-time AND needs simultaneous matches
// R9: OR breaks on any occurred event
// R10: state machine breaks entering break state
// R11: pass count one to 255 per event
// R12: same-time mode forces pass count one
// R13: byte high enable low means high lane
// R14: counters reload on arm, count down matches
// R15: event needs address, data and direction together
`include "bec_defines.vh"
`default_nettype none
module bec_top (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire [`BEC_ADDR_W-1:0] bus_addr,
    input  wire [`BEC_DATA_W-1:0] bus_data,
    input  wire                   bus_write,
    input  wire                   byte_high_lane_enable_n,
    input  wire                   cyc_valid,
    input  wire                   arm,
    input  wire [1:0]             comb_mode,
    input  wire [1:0]             event_select,
    input  wire [2:0]             ev0_addr_cond,
    input  wire [`BEC_ADDR_W-1:0] ev0_addr_1,
    input  wire [`BEC_ADDR_W-1:0] ev0_addr_2,
    input  wire [2:0]             ev0_data_cond,
    input  wire [`BEC_DATA_W-1:0] ev0_data_1,
    input  wire [`BEC_DATA_W-1:0] ev0_data_2,
    input  wire [`BEC_DATA_W-1:0] ev0_mask,
    input  wire [1:0]             ev0_acc,
    input  wire [`BEC_CNT_W-1:0]  ev0_pass,
    input  wire [2:0]             ev1_addr_cond,
    input  wire [`BEC_ADDR_W-1:0] ev1_addr_1,
    input  wire [`BEC_ADDR_W-1:0] ev1_addr_2,
    input  wire [2:0]             ev1_data_cond,
    input  wire [`BEC_DATA_W-1:0] ev1_data_1,
    input  wire [`BEC_DATA_W-1:0] ev1_data_2,
    input  wire [`BEC_DATA_W-1:0] ev1_mask,
    input  wire [1:0]             ev1_acc,
    input  wire [`BEC_CNT_W-1:0]  ev1_pass,
    output reg                    break_hit,
    output reg  [1:0]             event_done,
    output reg  [1:0]             state_now
);
    // ----------------------------------------------------------------
    // state machine states for transition mode
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;   // waiting for event_slot_first
    localparam [1:0] ST_SEEN  = 2'h1;   // first seen, wait for second
    localparam [1:0] ST_BREAK = 2'h2;   // designated break state

    // ----------------------------------------------------------------
    // timing and limits
    // ----------------------------------------------------------------
    // a bus cycle is taken on the edge where cyc_valid is high; its
    // result shows on event_done and break_hit after that same edge
    // all compare values are level inputs and act at once, so the
    // debugger side changes them only together with an arm pulse
    // only two event slots exist; a wider combiner needs more slots
    // and a longer state graph, which this block does not offer
    // break_hit holds until the next arm so a slow host cannot miss it
    // disarm lags the break by one cycle; a match in that cycle may
    // still count down a pass counter but can no longer raise a break

    // ----------------------------------------------------------------
    // comparators
    // ----------------------------------------------------------------
    wire [1:0] hit;                     // raw per-cycle matches
    // both slots watch the same bus; only their settings differ

    bec_event_cmp u_event_slot_first (
        .bus_addr                (bus_addr),
        .bus_data                (bus_data),
        .bus_write               (bus_write),
        .byte_high_lane_enable_n (byte_high_lane_enable_n),
        .cyc_valid               (cyc_valid),
        .addr_cond               (ev0_addr_cond),
        .addr_1                  (ev0_addr_1),
        .addr_2                  (ev0_addr_2),
        .data_cond               (ev0_data_cond),
        .data_1                  (ev0_data_1),
        .data_2                  (ev0_data_2),
        .data_mask               (ev0_mask),
        .acc_cond                (ev0_acc),
        .hit                     (hit[0])
    );

    bec_event_cmp u_event_slot_second (
        .bus_addr                (bus_addr),
        .bus_data                (bus_data),
        .bus_write               (bus_write),
        .byte_high_lane_enable_n (byte_high_lane_enable_n),
        .cyc_valid               (cyc_valid),
        .addr_cond               (ev1_addr_cond),
        .addr_1                  (ev1_addr_1),
        .addr_2                  (ev1_addr_2),
        .data_cond               (ev1_data_cond),
        .data_1                  (ev1_data_1),
        .data_2                  (ev1_data_2),
        .data_mask               (ev1_mask),
        .acc_cond                (ev1_acc),
        .hit                     (hit[1])
    );

    // ----------------------------------------------------------------
    // pass count loading
    // ----------------------------------------------------------------
    // a programmed zero is treated as one so the range stays 1..255
    function [`BEC_CNT_W-1:0] load_fn;
        input [1:0]            mode;
        input [`BEC_CNT_W-1:0] pass;
        begin
            if (mode == `BEC_MODE_ANDST)
                load_fn = `BEC_CNT_ONE;                // R12
            else if (pass == {`BEC_CNT_W{1'b0}})
                load_fn = `BEC_CNT_ONE;                // R11
            else
                load_fn = pass;                        // R11
        end
    endfunction

    reg  [`BEC_CNT_W-1:0] cnt0_r;       // remaining matches, event 0
    reg  [`BEC_CNT_W-1:0] cnt1_r;       // remaining matches, event 1
    reg                   armed_r;      // conditions live

    // same-time mode holds every counter at one: a lone match must not
    // use up its event, or a later joint match could never break
    wire same_time = (comb_mode == `BEC_MODE_ANDST);  // R8 R12

    // an occurrence is a match while the counter stands at one
    wire occ0 = armed_r && hit[0] && (cnt0_r == `BEC_CNT_ONE);  // R14
    wire occ1 = armed_r && hit[1] && (cnt1_r == `BEC_CNT_ONE);  // R14
    wire [1:0] occ = {occ1, occ0};
    wire [1:0] done_nxt = event_done | occ;

    // ----------------------------------------------------------------
    // pass counters and occurred flags
    // outside same-time mode a counter sits at zero once its event has
    // occurred, so further matches in the same run are ignored until the next arm
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt0_r     <= `BEC_CNT_ONE;
            cnt1_r     <= `BEC_CNT_ONE;
            armed_r    <= 1'b0;
            event_done <= 2'h0;
        end else if (arm) begin
            // reload from programmed values
            cnt0_r     <= load_fn(comb_mode, ev0_pass);  // R14
            cnt1_r     <= load_fn(comb_mode, ev1_pass);  // R14
            armed_r    <= 1'b1;
            event_done <= 2'h0;
        end else begin
            // counters stop at zero; further matches are ignored
            if (armed_r && hit[0] && !same_time && (cnt0_r != 8'h00))
                cnt0_r <= cnt0_r - `BEC_CNT_ONE;         // R14
            if (armed_r && hit[1] && !same_time && (cnt1_r != 8'h00))
                cnt1_r <= cnt1_r - `BEC_CNT_ONE;         // R14
            if (break_hit)
                armed_r <= 1'b0;   // disarm after break
            event_done <= done_nxt;
        end
    end

    // ----------------------------------------------------------------
    // combiner
    // ----------------------------------------------------------------
    reg       fire;                     // break condition this cycle
    reg [1:0] state_nxt;                // transition mode next state
    // only the selected mode feeds fire; same-time and OR look at this
    // cycle's occurrences, AND at the sticky flags, so its events may
    // come in any order and still break
    always @* begin
        fire      = 1'b0;
        state_nxt = state_now;
        case (comb_mode)
            `BEC_MODE_AND:
                // sticky flags, events may come at any time
                fire = (event_select != 2'h0) &&
                       ((done_nxt & event_select) == event_select);  // R7 R4
            `BEC_MODE_ANDST:
                fire = (event_select != 2'h0) &&
                       ((occ & event_select) == event_select);       // R8
            `BEC_MODE_OR:
                fire = |(occ & event_select);                        // R9
            default: begin
                case (state_now)
                    ST_IDLE:  if (occ0) state_nxt = ST_SEEN;         // R10
                    ST_SEEN:  if (occ1) state_nxt = ST_BREAK;        // R10
                    default:  state_nxt = state_now;
                endcase
                fire = armed_r && (state_now != ST_BREAK) &&
                       (state_nxt == ST_BREAK);                      // R10
            end
        endcase
        if (!armed_r)
            fire = 1'b0;
    end

    // ----------------------------------------------------------------
    // break flag and state register
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_hit <= 1'b0;
            state_now <= ST_IDLE;
        end else if (arm) begin
            // arm wins over a fire in the same cycle: a new run starts clean
            break_hit <= 1'b0;
            state_now <= ST_IDLE;
        end else begin
            if (fire)
                break_hit <= 1'b1;
            state_now <= state_nxt;
        end
    end
endmodule // bec_top
`default_nettype wire

/* hw/bec_defines.vh */
// Purpose: constants for the break event combiner
// Assumes: 16-bit monitored data bus, 24-bit address bus
// Notes:   definitions only
`ifndef BEC_DEFINES_VH
`define BEC_DEFINES_VH
// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define BEC_ADDR_W      24
`define BEC_DATA_W      16
`define BEC_NUM_EV      2
`define BEC_CNT_W       8
`define BEC_CNT_ONE     8'h01
// ----------------------------------------------------------------
// data / address match conditions (3-bit code, eight of them)
// ----------------------------------------------------------------
`define BEC_CMP_EQ      3'h0
`define BEC_CMP_NE      3'h1
`define BEC_CMP_GT      3'h2
`define BEC_CMP_GE      3'h3
`define BEC_CMP_LT      3'h4
`define BEC_CMP_LE      3'h5
`define BEC_CMP_IN      3'h6
`define BEC_CMP_OUT     3'h7
// ----------------------------------------------------------------
// access direction qualifier
// ----------------------------------------------------------------
`define BEC_ACC_READ    2'h0
`define BEC_ACC_WRITE   2'h1
`define BEC_ACC_RW      2'h2
// ----------------------------------------------------------------
// combination modes
// ----------------------------------------------------------------
`define BEC_MODE_AND    2'h0
`define BEC_MODE_ANDST  2'h1
`define BEC_MODE_OR     2'h2
`define BEC_MODE_STATE  2'h3
// ----------------------------------------------------------------
// byte lane masks
// ----------------------------------------------------------------
`define BEC_MASK_LOW    16'h00FF
`define BEC_MASK_HIGH   16'hFF00
`define BEC_MASK_WORD   16'hFFFF
`endif

/* hw/bec_event_cmp.v */
// Purpose: one data-access event comparator
// Assumes: bus cycle fields valid when cyc_valid is high
// Notes:   combinational match, no state
`include "bec_defines.vh"
`default_nettype none
module bec_event_cmp (
    input  wire [`BEC_ADDR_W-1:0] bus_addr,
    input  wire [`BEC_DATA_W-1:0] bus_data,
    input  wire                   bus_write,
    input  wire                   byte_high_lane_enable_n,
    input  wire                   cyc_valid,
    input  wire [2:0]             addr_cond,
    input  wire [`BEC_ADDR_W-1:0] addr_1,
    input  wire [`BEC_ADDR_W-1:0] addr_2,
    input  wire [2:0]             data_cond,
    input  wire [`BEC_DATA_W-1:0] data_1,
    input  wire [`BEC_DATA_W-1:0] data_2,
    input  wire [`BEC_DATA_W-1:0] data_mask,
    input  wire [1:0]             acc_cond,
    output wire                   hit
);
    // ----------------------------------------------------------------
    // generic compare, shared by address and data paths
    // ----------------------------------------------------------------
    function cmp_fn;
        input [2:0]  cond;
        input [23:0] v;
        input [23:0] a;
        input [23:0] b;
        begin
            case (cond)
                `BEC_CMP_EQ:  cmp_fn = (v == a);
                `BEC_CMP_NE:  cmp_fn = (v != a);
                `BEC_CMP_GT:  cmp_fn = (v > a);
                `BEC_CMP_GE:  cmp_fn = (v >= a);
                `BEC_CMP_LT:  cmp_fn = (v < a);
                `BEC_CMP_LE:  cmp_fn = (v <= a);
                `BEC_CMP_IN:  cmp_fn = (v >= a) && (v <= b);  // R1
                default:      cmp_fn = (v < a) || (v > b);
            endcase
        end
    endfunction

    // lanes not carrying data are dropped from the mask
    reg  [`BEC_DATA_W-1:0] lane_mask;   // valid lanes of this cycle
    always @* begin
        lane_mask = `BEC_MASK_WORD;                    // R3
        if (byte_high_lane_enable_n)
            lane_mask = `BEC_MASK_LOW;                 // R5 R13
        else if (bus_addr[0])
            lane_mask = `BEC_MASK_HIGH;                // R6 R13
    end

    wire [`BEC_DATA_W-1:0] eff_mask = data_mask & lane_mask;
    wire addr_ok = cmp_fn(addr_cond, bus_addr, addr_1, addr_2);
    wire data_ok = cmp_fn(data_cond, {8'h00, bus_data & eff_mask},
                          {8'h00, data_1 & eff_mask},
                          {8'h00, data_2 & eff_mask});  // R1 R3
    wire acc_ok  = (acc_cond == `BEC_ACC_RW) ||
                   ((acc_cond == `BEC_ACC_WRITE) && bus_write) ||
                   ((acc_cond == `BEC_ACC_READ) && !bus_write);  // R2

    assign hit = cyc_valid && addr_ok && data_ok && acc_ok;  // R15
endmodule // bec_event_cmp
`default_nettype wire

/* bench/bec_chk.sv */
// Purpose: port checks for bec_top
// Assumes: one clock, rst_n async active low
// Notes:   bound into bec_top at the foot
`include "bec_defines.vh"
`default_nettype none
module bec_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cyc_valid,
    input wire logic       arm,
    input wire logic [1:0] comb_mode,
    input wire logic [1:0] event_select,
    input wire logic       break_hit,
    input wire logic [1:0] event_done,
    input wire logic [1:0] state_now
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // steps of a run
    // ----------------------------------------
    sequence s_armed;     // arm taken, then first armed cycle
        arm ##1 1'b1;
    endsequence
    sequence s_new_done;  // some event newly occurred
        (event_done & ~$past(event_done)) != 2'h0;
    endsequence
    sequence s_sel_any;   // a selected event has occurred
        !arm && (event_done & event_select) != 2'h0;
    endsequence
    a_arm_clears: assert property (s_armed |-> !break_hit && event_done == 2'h0)
        else $error("arm left flags set");
    a_break_stays: assert property (break_hit && !arm |=> break_hit)
        else $error("break dropped");
    a_done_stays: assert property (!arm && comb_mode == `BEC_MODE_AND |=>
        (event_done & $past(event_done)) == $past(event_done))
        else $error("done flag dropped");
    a_break_cause: assert property ($rose(break_hit) |-> $past(cyc_valid))
        else $error("break without bus cycle");
    a_done_cause: assert property (s_new_done |-> $past(cyc_valid))
        else $error("event without bus cycle");
    a_or_break: assert property (comb_mode == `BEC_MODE_OR ##0 s_sel_any |-> break_hit)
        else $error("or mode missed break");
    a_and_break: assert property (!arm && comb_mode == `BEC_MODE_AND && event_select != 2'h0 &&
        (event_done & event_select) == event_select |-> break_hit)
        else $error("and mode missed break");
    a_state_break: assert property (!arm && comb_mode == `BEC_MODE_STATE && state_now == 2'h2 |-> break_hit)
        else $error("break state without break");
endmodule // bec_chk
bind bec_top bec_chk i_chk (.clk(clk), .rst_n(rst_n), .cyc_valid(cyc_valid), .arm(arm),
    .comb_mode(comb_mode), .event_select(event_select), .break_hit(break_hit), .event_done(event_done),
    .state_now(state_now));
`default_nettype wire

/* bench/bec_bus_model.sv */
// Purpose: monitored target bus, one cycle per call
// Assumes: cycles launched just after a rising edge
// Notes:   a released bus shows the inverse of its last value
`default_nettype none
module bec_bus_model (
    input  wire logic        clk,
    output var  logic [23:0] bus_addr,
    output var  logic [15:0] bus_data,
    output var  logic        bus_write,
    output var  logic        byte_high_lane_enable_n,
    output var  logic        cyc_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        bus_addr = 24'h00_0000;
        bus_data = 16'h0000;
        bus_write = 1'b0;
        byte_high_lane_enable_n = 1'b1;
        cyc_valid = 1'b0;
    end
    // one bus cycle, held for the single clock that takes it
    task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic w, input logic bh);
        @(posedge clk);
        bus_addr <= a;
        bus_data <= d;
        bus_write <= w;
        byte_high_lane_enable_n <= bh;
        cyc_valid <= 1'b1;
        @(posedge clk);
        cyc_valid <= 1'b0;
        bus_addr <= ~a; // no stale fields once released
        bus_data <= ~d;
        bus_write <= ~w;
        byte_high_lane_enable_n <= ~bh;
    endtask
endmodule // bec_bus_model
`default_nettype wire

/* bench/tb_break_event_combiner.sv */
// Purpose: self-checking bench for bec_top
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes:   address condition fixed to equal
`include "bec_defines.vh"
`default_nettype none
module tb_break_event_combiner;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        arm = 1'b0;
    logic [1:0]  md = 2'h0;  // combination mode
    logic [1:0]  sl = 2'h0;  // event select
    logic [23:0] ad [2];     // event address
    logic [2:0]  dc [2];     // data condition
    logic [15:0] v1 [2];
    logic [15:0] v2 [2];
    logic [15:0] mk [2];     // data mask
    logic [1:0]  ac [2];     // access qualifier
    logic [7:0]  ps [2];     // pass count
    wire  [23:0] b_a;
    wire  [15:0] b_d;
    wire         b_w, b_h, b_v, brk;
    wire  [1:0]  done, st;
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #2.5 clk = ~clk;
    bec_bus_model i_bus (.clk(clk), .bus_addr(b_a), .bus_data(b_d), .bus_write(b_w),
        .byte_high_lane_enable_n(b_h), .cyc_valid(b_v));
    bec_top i_dut (.clk(clk), .rst_n(rst_n), .bus_addr(b_a), .bus_data(b_d), .bus_write(b_w),
        .byte_high_lane_enable_n(b_h), .cyc_valid(b_v), .arm(arm), .comb_mode(md), .event_select(sl),
        .ev0_addr_cond(`BEC_CMP_EQ), .ev0_addr_1(ad[0]), .ev0_addr_2(24'h00_0000), .ev0_data_cond(dc[0]),
        .ev0_data_1(v1[0]), .ev0_data_2(v2[0]), .ev0_mask(mk[0]), .ev0_acc(ac[0]), .ev0_pass(ps[0]),
        .ev1_addr_cond(`BEC_CMP_EQ), .ev1_addr_1(ad[1]), .ev1_addr_2(24'h00_0000), .ev1_data_cond(dc[1]),
        .ev1_data_1(v1[1]), .ev1_data_2(v2[1]), .ev1_mask(mk[1]), .ev1_acc(ac[1]), .ev1_pass(ps[1]),
        .break_hit(brk), .event_done(done), .state_now(st));
    task stop_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task cfg(input int e, input logic [23:0] a, input logic [2:0] c, input logic [15:0] x, y, m,
             input logic [1:0] q, input logic [7:0] p);
        @(posedge clk);
        ad[e] <= a;
        dc[e] <= c;
        v1[e] <= x;
        v2[e] <= y;
        mk[e] <= m;
        ac[e] <= q;
        ps[e] <= p;
    endtask
    // arm with new mode, mode and select changed only here
    task go(input logic [1:0] m, input logic [1:0] s);
        @(posedge clk);
        md <= m;
        sl <= s;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
    endtask
    // one bus cycle, then let the taking edge settle
    task bc(input logic [23:0] a, input logic [15:0] d, input logic w, input logic h);
        i_bus.cyc(a, d, w, h);
        #1;
    endtask
    // single event write compare in or mode
    task t1(input logic [23:0] a, input logic [15:0] x, m, d, input logic h, input logic e);
        cfg(0, a, `BEC_CMP_EQ, x, 16'h0000, m, `BEC_ACC_WRITE, 8'h01);
        go(`BEC_MODE_OR, 2'h1);
        bc(a, d, 1'b1, h);
        chk(brk, e);
    endtask
    task t_access;
        for (int a = 0; a < 3; a++)
            for (int w = 0; w < 2; w++) begin
                cfg(0, 24'h00_0512, `BEC_CMP_EQ, 16'h0203, 16'h0000, `BEC_MASK_WORD, a[1:0], 8'h01);
                go(`BEC_MODE_OR, 2'h1);
                bc(24'h00_0512, 16'h0203, w[0], 1'b0);
                chk(brk, a == 2 || a == w);
            end
        go(`BEC_MODE_OR, 2'h1);
        bc(24'h00_0514, 16'h0203, 1'b0, 1'b0);
        chk(brk, 1'b0);
    endtask
    // two bus values against every data condition, range 0010..0020
    task t_cond;
        for (int i = 0; i < 16; i++) begin
            cfg(0, 24'h00_0512, i[2:0], 16'h0010, 16'h0020, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h01);
            go(`BEC_MODE_OR, 2'h1);
            bc(24'h00_0512, i[3] ? 16'h0030 : 16'h0010, 1'b1, 1'b0);
            chk(brk, ((i[3] ? 8'h8E : 8'h69) >> i[2:0]) & 8'h01);
        end
    endtask
    task t_lanes;
        cfg(0, 24'h00_0519, `BEC_CMP_EQ, 16'h0300, 16'h0000, `BEC_MASK_HIGH, `BEC_ACC_WRITE, 8'h01);
        cfg(1, 24'h00_051A, `BEC_CMP_EQ, 16'h0002, 16'h0000, `BEC_MASK_LOW, `BEC_ACC_WRITE, 8'h01);
        go(`BEC_MODE_AND, 2'h3);
        bc(24'h00_0519, 16'h0302, 1'b1, 1'b0);
        chk(brk, 1'b0);
        bc(24'h00_051A, 16'h0302, 1'b1, 1'b1);
        chk(brk, 1'b1);
        t1(24'h00_0516, 16'h0003, `BEC_MASK_WORD, 16'h0503, 1'b1, 1'b1);
        t1(24'h00_0515, 16'h0300, `BEC_MASK_WORD, 16'h0315, 1'b1, 1'b0);
        t1(24'h00_0515, 16'h0300, `BEC_MASK_WORD, 16'h0315, 1'b0, 1'b1);
        t1(24'h00_0512, 16'h0003, `BEC_MASK_LOW, 16'h0503, 1'b0, 1'b1);
        t1(24'h00_0512, 16'h0003, `BEC_MASK_WORD, 16'h0503, 1'b0, 1'b0);
    endtask
    task t_pass;
        cfg(0, 24'h00_0512, `BEC_CMP_EQ, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'hFF);
        go(`BEC_MODE_OR, 2'h1);
        repeat (254) bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(brk, 1'b0);
        bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(brk, 1'b1);
        cfg(0, 24'h00_0512, `BEC_CMP_EQ, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h02);
        go(`BEC_MODE_OR, 2'h1);
        bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(done, 2'h0);
        bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(done, 2'h1);
    endtask
    // event 0 above, event 1 below, both only at 0203
    task t_andst;
        cfg(0, 24'h00_0512, `BEC_CMP_GE, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h03);
        cfg(1, 24'h00_0512, `BEC_CMP_LE, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h03);
        go(`BEC_MODE_ANDST, 2'h3);
        bc(24'h00_0512, 16'h0300, 1'b1, 1'b0);
        bc(24'h00_0512, 16'h0100, 1'b1, 1'b0);
        chk(brk, 1'b0);
        bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(brk, 1'b1);
    endtask
    // event 1 needs two passes, so its early match is counted, not lost
    task t_state;
        cfg(0, 24'h00_0512, `BEC_CMP_EQ, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h01);
        cfg(1, 24'h00_0514, `BEC_CMP_EQ, 16'h0203, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h02);
        go(`BEC_MODE_STATE, 2'h3);
        bc(24'h00_0514, 16'h0203, 1'b1, 1'b0);
        chk(st, 2'h0);
        bc(24'h00_0512, 16'h0203, 1'b1, 1'b0);
        chk(st, 2'h1);
        bc(24'h00_0514, 16'h0203, 1'b1, 1'b0);
        chk({st, brk}, 3'h5);
    endtask
    initial begin
        cfg(0, 24'h00_0000, `BEC_CMP_EQ, 16'h0000, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h01);
        cfg(1, 24'h00_0000, `BEC_CMP_EQ, 16'h0000, 16'h0000, `BEC_MASK_WORD, `BEC_ACC_RW, 8'h01);
        // two cfg edges plus ten make the twelve reset cycles
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_access;
        t_cond;
        t_lanes;
        t_pass;
        t_andst;
        t_state;
        stop_test;
    end
    // watchdog, well beyond the ~700 cycles of the run
    initial begin
        #40000;
        n_mismatch++;
        stop_test;
    end
endmodule // tb_break_event_combiner
`default_nettype wire
